// file: core/ros_pkg.sv
// Package with the register map, field layout and types of the pin routing block.
// Behaviour
// - Output route register holds two 6-bit selectors
// - Selectors 1..12 pick comparators, serial, SPI outputs
// - Selectors 13..27 pick compare, serial, SPI, modulator
// - Selector zero leaves the pin disconnected
// - Reset clears every output selector to null
// - Muxing blocks contention between pins and functions
// - One source may feed many destinations
// - Input selector naming missing pin gives no input
// - Output fields of missing pins ignore writes
// - At most 24 pins; pins 4, 12 absent
// - Locked mapping writes complete but change nothing
// - Lock bit is control register bit 6
// - Lock bit holds until next key sequence
// - Shadow copies trigger mismatch reset on change
// - One-way option keeps lock set until reset
// - One-way option defaults set when unprogrammed
// - Lock bit resets to unlocked
// - Input selectors reset to all ones
// - Each peripheral input has a 6-bit selector
package ros_pkg;
    localparam int SEL_W = 6; // Width of every selector field.
    localparam int NUM_PINS = 26; // Pin numbers 0 to 25.
    localparam int NUM_FUNCS = 27; // Output functions 1 to 27.
    localparam int NUM_OUT_REGS = 13; // Output route registers, two pins each.
    localparam int NUM_IN_REGS = 18; // Input route registers, two inputs each.
    localparam int NUM_INPUTS = 2 * NUM_IN_REGS; // Remappable peripheral inputs.
    localparam int ADDR_W = 8; // Byte address width of the slave.
    localparam logic [SEL_W-1:0] MISSING_PIN_A = 6'h04; // First absent pin.
    localparam logic [SEL_W-1:0] MISSING_PIN_B = 6'h0C; // Second absent pin.
    localparam logic [SEL_W-1:0] INPUT_ONLY_PIN = 6'h19; // Pin with no output field.
    localparam logic [SEL_W-1:0] OUT_SEL_RESET = 6'h00; // Null output function.
    localparam logic [SEL_W-1:0] IN_SEL_RESET = 6'h3F; // Input tied low.
    localparam logic [7:0] KEY_FIRST = 8'h46; // First key byte.
    localparam logic [7:0] KEY_SECOND = 8'h57; // Second key byte.
    localparam int LOCK_BIT = 6; // Lock bit position in the control register.
    localparam int FIELD0_LSB = 0; // Low selector field position.
    localparam int FIELD1_LSB = 8; // High selector field position.
    localparam logic [ADDR_W-1:0] OSC_CTRL_ADDR = 8'h00; // Oscillator control register.
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04; // Block status register.
    localparam logic [ADDR_W-1:0] OUT_BASE_ADDR = 8'h40; // First output route register.
    localparam logic [ADDR_W-1:0] IN_BASE_ADDR = 8'h80; // First input route register.
    localparam int ST_ONE_WAY = 0; // Status bit: one-way option latched.
    localparam int ST_MISMATCH = 1; // Status bit: shadow mismatch seen.
    localparam int ST_KEY_LSB = 2; // Status bits 3:2: key sequence state.

    // Key sequence states.
    typedef enum logic [1:0] {
        ROS_KEY_IDLE = 2'b00,
        ROS_KEY_ONE = 2'b01,
        ROS_KEY_ARMED = 2'b10
    } ros_key_t;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } ros_av_req_t;
endpackage

// file: core/ros_pin_route.sv
// Pin routing block: route selectors, write lock with key sequence, shadow monitor.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module ros_pin_route (
    input wire logic clk_in, // System clock, 200 MHz.
    input wire logic rstn_in, // Asynchronous reset, active low.
    input wire ros_pkg::ros_av_req_t av_req_in, // Avalon request group.
    output logic [31:0] av_readdata_out, // Avalon read data.
    output logic av_waitrequest_out, // Avalon wait request.
    input wire logic one_way_lock_cfg_in, // Configuration word bit 15, high when unprogrammed.
    input wire logic [ros_pkg::NUM_FUNCS:1] periph_out_in, // Peripheral outputs by number.
    output logic [ros_pkg::NUM_PINS-1:0] pin_data_out, // Routed data per pin.
    output logic [ros_pkg::NUM_PINS-1:0] pin_oe_out, // High while a function drives the pin.
    input wire logic [ros_pkg::NUM_PINS-1:0] pin_data_in, // Pin levels.
    output logic [ros_pkg::NUM_INPUTS-1:0] periph_in_out, // Mapped peripheral inputs.
    output logic mismatch_reset_out // Configuration mismatch reset request.
);
    import ros_pkg::*;

    logic ack_q, ack_d; // High in the cycle the answer is given.
    logic [31:0] rdata_q, rdata_d; // Read data register.
    logic [SEL_W-1:0] out_sel_q [NUM_PINS]; // Output selector per pin.
    logic [SEL_W-1:0] out_sel_d [NUM_PINS];
    logic [SEL_W-1:0] out_shd_q [NUM_PINS]; // Shadow copy of output selectors.
    logic [SEL_W-1:0] in_sel_q [NUM_INPUTS]; // Selector per peripheral input.
    logic [SEL_W-1:0] in_sel_d [NUM_INPUTS];
    logic [SEL_W-1:0] in_shd_q [NUM_INPUTS]; // Shadow copy of input selectors.
    logic lock_q, lock_d; // Mapping lock bit.
    logic one_way_q, one_way_d; // One-way option caught after reset.
    logic cfg_seen_q, cfg_seen_d; // Option has been sampled.
    ros_key_t key_q, key_d; // Key sequence state.
    logic mism_q, mism_d; // Mismatch flag, held until reset.
    logic [NUM_PINS-1:0] pin_q, pin_d; // Registered pin data.
    logic [NUM_PINS-1:0] oe_q, oe_d; // Registered pin enables.
    logic [NUM_INPUTS-1:0] pin_in_q, pin_in_d; // Registered peripheral inputs.
    logic wr_go; // A write takes effect this edge.
    logic shd_diff; // Shadow and live copies differ.

    // A pin has an output field unless absent or input only.
    function automatic logic out_field_ok(input int p);
        logic [SEL_W-1:0] pn;
        pn = SEL_W'(p);
        return (pn != MISSING_PIN_A) && (pn != MISSING_PIN_B) && (pn != INPUT_ONLY_PIN);
    endfunction

    // A pin number is a valid input source only if it exists.
    function automatic logic in_pin_ok(input logic [SEL_W-1:0] pn);
        return (pn < SEL_W'(NUM_PINS)) && (pn != MISSING_PIN_A) && (pn != MISSING_PIN_B);
    endfunction

    // One wait cycle: the answer comes in the cycle after the request is seen.
    assign av_waitrequest_out = (av_req_in.read | av_req_in.write) & ~ack_q;
    assign wr_go = av_req_in.write & ack_q;
    assign av_readdata_out = rdata_q;
    assign pin_data_out = pin_q;
    assign pin_oe_out = oe_q;
    assign periph_in_out = pin_in_q;
    assign mismatch_reset_out = mism_q;

    // Bus handshake and read data capture, taken while waitrequest is high.
    always_comb begin
        int k;
        k = 0;
        ack_d = (av_req_in.read | av_req_in.write) & ~ack_q;
        rdata_d = rdata_q;
        if (av_req_in.read && !ack_q) begin
            rdata_d = 32'h0000_0000; // Unmapped addresses read as zero.
            if (av_req_in.address == OSC_CTRL_ADDR) begin
                rdata_d[LOCK_BIT] = lock_q;
            end else if (av_req_in.address == STATUS_ADDR) begin
                rdata_d[ST_ONE_WAY] = one_way_q;
                rdata_d[ST_MISMATCH] = mism_q;
                rdata_d[ST_KEY_LSB +: 2] = key_q;
            end else if (av_req_in.address[ADDR_W-1:6] == OUT_BASE_ADDR[ADDR_W-1:6]) begin
                k = int'(av_req_in.address[5:2]);
                if (k < NUM_OUT_REGS) begin
                    // Absent pin fields read as zero since they never change.
                    rdata_d[FIELD0_LSB +: SEL_W] = out_sel_q[2*k];
                    rdata_d[FIELD1_LSB +: SEL_W] = out_sel_q[2*k+1];
                end
            end else if (av_req_in.address[ADDR_W-1:7] == IN_BASE_ADDR[ADDR_W-1:7]) begin
                k = int'(av_req_in.address[6:2]);
                if (k < NUM_IN_REGS) begin
                    rdata_d[FIELD0_LSB +: SEL_W] = in_sel_q[2*k];
                    rdata_d[FIELD1_LSB +: SEL_W] = in_sel_q[2*k+1];
                end
            end
        end
    end

    // Register the bus answer.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Key sequence and lock bit. Any write elsewhere breaks the sequence, so a stray
    // store between the key bytes cannot leave the lock open to a later write.
    always_comb begin
        key_d = key_q;
        lock_d = lock_q;
        one_way_d = one_way_q;
        cfg_seen_d = 1'b1;
        if (!cfg_seen_q) begin
            one_way_d = one_way_cfg_sample();
        end
        if (wr_go) begin
            key_d = ROS_KEY_IDLE;
            if (av_req_in.address == OSC_CTRL_ADDR && av_req_in.byteenable[0]) begin
                case (key_q)
                    ROS_KEY_IDLE: begin
                        if (av_req_in.writedata[7:0] == KEY_FIRST) begin
                            key_d = ROS_KEY_ONE;
                        end
                    end
                    ROS_KEY_ONE: begin
                        if (av_req_in.writedata[7:0] == KEY_SECOND) begin
                            key_d = ROS_KEY_ARMED;
                        end else if (av_req_in.writedata[7:0] == KEY_FIRST) begin
                            key_d = ROS_KEY_ONE;
                        end
                    end
                    ROS_KEY_ARMED: begin
                        // With the one-way option a set lock stays set until reset.
                        if (!(one_way_q && lock_q)) begin
                            lock_d = av_req_in.writedata[LOCK_BIT];
                        end
                    end
                    default: begin
                        key_d = ROS_KEY_IDLE;
                    end
                endcase
            end
        end
    end

    // The option input is a fuse level; it is read by a clocked stage after release.
    function automatic logic one_way_cfg_sample();
        return one_way_lock_cfg_in;
    endfunction

    // Lock state registers; the lock never times out on its own.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            key_q <= ROS_KEY_IDLE;
            lock_q <= 1'b0;
            one_way_q <= 1'b1;
            cfg_seen_q <= 1'b0;
        end else begin
            key_q <= key_d;
            lock_q <= lock_d;
            one_way_q <= one_way_d;
            cfg_seen_q <= cfg_seen_d;
        end
    end

    // Route register writes with byte lanes; blocked while locked.
    always_comb begin
        int k;
        logic map_wr;
        k = 0;
        map_wr = wr_go && !lock_q;
        out_sel_d = out_sel_q;
        in_sel_d = in_sel_q;
        if (map_wr && av_req_in.address[ADDR_W-1:6] == OUT_BASE_ADDR[ADDR_W-1:6]) begin
            k = int'(av_req_in.address[5:2]);
            if (k < NUM_OUT_REGS) begin
                if (av_req_in.byteenable[0] && out_field_ok(2*k)) begin
                    out_sel_d[2*k] = av_req_in.writedata[FIELD0_LSB +: SEL_W];
                end
                if (av_req_in.byteenable[1] && out_field_ok(2*k+1)) begin
                    out_sel_d[2*k+1] = av_req_in.writedata[FIELD1_LSB +: SEL_W];
                end
            end
        end
        if (map_wr && av_req_in.address[ADDR_W-1:7] == IN_BASE_ADDR[ADDR_W-1:7]) begin
            k = int'(av_req_in.address[6:2]);
            if (k < NUM_IN_REGS) begin
                if (av_req_in.byteenable[0]) begin
                    in_sel_d[2*k] = av_req_in.writedata[FIELD0_LSB +: SEL_W];
                end
                if (av_req_in.byteenable[1]) begin
                    in_sel_d[2*k+1] = av_req_in.writedata[FIELD1_LSB +: SEL_W];
                end
            end
        end
    end

    // Live selectors and their shadows load from the same next value, so they can
    // only part if a stored bit is disturbed.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int p = 0; p < NUM_PINS; p++) begin
                out_sel_q[p] <= OUT_SEL_RESET;
                out_shd_q[p] <= OUT_SEL_RESET;
            end
            for (int i = 0; i < NUM_INPUTS; i++) begin
                in_sel_q[i] <= IN_SEL_RESET;
                in_shd_q[i] <= IN_SEL_RESET;
            end
        end else begin
            out_sel_q <= out_sel_d;
            out_shd_q <= out_sel_d;
            in_sel_q <= in_sel_d;
            in_shd_q <= in_sel_d;
        end
    end

    // Shadow comparison over every mapping field.
    always_comb begin
        shd_diff = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (out_sel_q[p] != out_shd_q[p]) begin
                shd_diff = 1'b1;
            end
        end
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (in_sel_q[i] != in_shd_q[i]) begin
                shd_diff = 1'b1;
            end
        end
        mism_d = mism_q | shd_diff; // Held until device reset acts on it.
    end

    // Output and input muxes. Each pin picks at most one function and each input picks
    // at most one pin, so two drivers can never meet on one wire; any source may still
    // fan out to many destinations.
    always_comb begin
        int f;
        f = 0;
        pin_d = '0;
        oe_d = '0;
        pin_in_d = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            f = int'(out_sel_q[p]);
            if (f >= 1 && f <= NUM_FUNCS && out_field_ok(p)) begin
                pin_d[p] = periph_out_in[f];
                oe_d[p] = 1'b1;
            end
            // Zero and undefined codes leave the pin disconnected.
        end
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (in_pin_ok(in_sel_q[i])) begin
                pin_in_d[i] = pin_data_in[in_sel_q[i][4:0]];
            end
        end
    end

    // Register the routed data and the mismatch flag.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_q <= '0;
            oe_q <= '0;
            pin_in_q <= '0;
            mism_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            oe_q <= oe_d;
            pin_in_q <= pin_in_d;
            mism_q <= mism_d;
        end
    end
endmodule

// file: bench/ros_pin_route_sva.sv
// Checker for the pin routing block, bound to its top-level ports.
`timescale 1ns/100ps
module ros_pin_route_sva (
    input wire logic clk_in, // System clock.
    input wire logic rstn_in, // Reset, active low.
    input wire ros_pkg::ros_av_req_t av_req_in, // Bus request group.
    input wire logic [31:0] av_readdata_out, // Bus read data.
    input wire logic av_waitrequest_out, // Bus wait request.
    input wire logic [ros_pkg::NUM_PINS-1:0] pin_oe_out, // Pin enables.
    input wire logic [ros_pkg::NUM_INPUTS-1:0] periph_in_out, // Mapped peripheral inputs.
    input wire logic mismatch_reset_out // Mismatch reset request.
);
    import ros_pkg::*;
    logic req; // Any request pending.
    logic done; // Request answered this cycle.
    logic out_wr_q; // An output route write was answered since reset.
    logic out_wr_d; // Next value.
    logic in_wr_q; // An input route write at 0x80 to 0xBF was answered since reset.
    logic in_wr_d; // Next value.
    assign req = av_req_in.read | av_req_in.write;
    assign done = req & ~av_waitrequest_out;
    // Remember route writes so that routing seen at the pins needs a cause.
    always_comb begin
        out_wr_d = out_wr_q | (done & av_req_in.write & (av_req_in.address[7:6] == 2'b01));
        in_wr_d = in_wr_q | (done & av_req_in.write & (av_req_in.address[7:6] == 2'b10));
    end
    // Helper flags are cleared by reset, as the selectors they shadow return to their reset codes.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_wr_q <= 1'b0;
            in_wr_q <= 1'b0;
        end else begin
            out_wr_q <= out_wr_d;
            in_wr_q <= in_wr_d;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    wait_first_a: assert property (req && !$past(req) |-> av_waitrequest_out)
        else $error("wait request low in first request cycle");
    wait_once_a: assert property (req && av_waitrequest_out |=> !av_waitrequest_out)
        else $error("request not answered after one cycle");
    unmapped_zero_a: assert property (done && av_req_in.read && av_req_in.address == 8'h3C
        |-> av_readdata_out == 32'h0) else $error("unmapped read not zero");
    field_width_a: assert property (done && av_req_in.read && ^av_req_in.address[7:6]
        |-> av_readdata_out[31:14] == 18'h0 && av_readdata_out[7:6] == 2'h0)
        else $error("route register unused bits not zero");
    absent_oe_a: assert property (!(pin_oe_out[4] | pin_oe_out[12] | pin_oe_out[25]))
        else $error("absent pin driven");
    route_reset_a: assert property (pin_oe_out != '0 |-> out_wr_q)
        else $error("pin driven without any route write");
    input_reset_a: assert property (periph_in_out != '0 |-> in_wr_q)
        else $error("peripheral input high without any input route write");
    mism_quiet_a: assert property (!mismatch_reset_out)
        else $error("mismatch reset without disturbance");
    cover property (done && av_req_in.write && av_req_in.address == OSC_CTRL_ADDR);
    cover property (pin_oe_out != '0);
    cover property (periph_in_out != '0);
endmodule

// file: bench/ros_far_model.sv
// Far-side model: peripheral output levels and the pads of the remappable pins.
`timescale 1ns/100ps
module ros_far_model (
    input wire logic [ros_pkg::NUM_FUNCS:1] funcs_in, // Peripheral levels from the bench.
    input wire logic [ros_pkg::NUM_PINS-1:0] ext_in, // Outside drivers on each pad.
    input wire logic [ros_pkg::NUM_PINS-1:0] drv_data_in, // Routed data from the block.
    input wire logic [ros_pkg::NUM_PINS-1:0] drv_oe_in, // Routed enables from the block.
    output logic [ros_pkg::NUM_FUNCS:1] periph_out, // Peripheral outputs to the block.
    output logic [ros_pkg::NUM_PINS-1:0] pad_out // Resolved pad levels.
);
    import ros_pkg::*;
    // Peripherals present the levels the bench chose.
    assign periph_out = funcs_in;
    // A pad has one owner at a time: the block where it drives, else the outside driver.
    assign pad_out = (drv_oe_in & drv_data_in) | (~drv_oe_in & ext_in);
endmodule

// file: bench/ros_pin_route_tb_top.sv
// Testbench for the pin routing block: bus tasks, routing, input mapping and lock scenarios.
`timescale 1ns/100ps
module ros_pin_route_tb_top;
    import ros_pkg::*;
    logic clk_in = 1'b0; // Bench clock.
    logic rstn_in = 1'b0; // Bench reset.
    ros_av_req_t req = '0; // Bus request driven by the bench.
    logic cfg = 1'b1; // One-way option level.
    logic [NUM_FUNCS:1] funcs = '0; // Peripheral levels.
    logic [NUM_PINS-1:0] ext = '0; // Outside pad levels.
    logic [31:0] rdata, rv, d; // Read data, last answer, scratch.
    logic wait_req, mism; // Wait request and mismatch reset.
    logic [NUM_FUNCS:1] periph; // Peripheral outputs.
    logic [NUM_PINS-1:0] pad, pdata, poe; // Pads and routed pins.
    logic [NUM_INPUTS-1:0] pmap; // Mapped peripheral inputs.
    int miscompares = 0;
    int samples_checked = 0;
    int ks[4] = '{1, 2, 6, 12}; // Route registers checked: 1 has no absent field; 2, 6 and 12 each hold a pin with no output field.
    always #2.5 clk_in = ~clk_in;
    ros_pin_route DUT (.clk_in(clk_in), .rstn_in(rstn_in), .av_req_in(req),
        .av_readdata_out(rdata), .av_waitrequest_out(wait_req), .one_way_lock_cfg_in(cfg),
        .periph_out_in(periph), .pin_data_out(pdata), .pin_oe_out(poe), .pin_data_in(pad),
        .periph_in_out(pmap), .mismatch_reset_out(mism));
    ros_far_model FAR (.funcs_in(funcs), .ext_in(ext), .drv_data_in(pdata),
        .drv_oe_in(poe), .periph_out(periph), .pad_out(pad));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Holds the request until wait request is sampled low, then lets one edge pass.
    task automatic bus(logic rd, logic [7:0] a, logic [31:0] wd, logic [3:0] be);
        int n;
        n = 0;
        req.read <= rd;
        req.write <= !rd;
        req.address <= a;
        req.writedata <= wd;
        req.byteenable <= be;
        do begin
            @(posedge clk_in);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        rv = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk_in);
        // A slave that never answers ends the run at once, through the closing task.
        if (n >= 50) begin
            check("bus answer", 32'h0, 32'h1);
            stop_test();
        end
    endtask
    task automatic key(logic v);
        bus(0, OSC_CTRL_ADDR, {24'h0, KEY_FIRST}, 4'h1);
        bus(0, OSC_CTRL_ADDR, {24'h0, KEY_SECOND}, 4'h1);
        bus(0, OSC_CTRL_ADDR, {24'h0, 1'b0, v, 6'h0}, 4'h1);
    endtask
    task automatic do_reset(logic c);
        rstn_in <= 1'b0;
        cfg <= c;
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
    endtask
    // Expected read-back of output route register k; fields of absent pins stay zero.
    function automatic logic [31:0] out_exp(int k, logic [31:0] wd);
        logic [31:0] e;
        e = wd & 32'h00003F3F;
        if (k == 2 || k == 6) e[5:0] = 6'h00;
        if (k == 12) e[13:8] = 6'h00;
        return e;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog sized well beyond the length of all tests.
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
    initial begin
        logic [NUM_FUNCS:1] fv;
        logic [5:0] c;
        logic [NUM_PINS-1:0] e;
        int p;
        rv = $urandom(32'hA504);
        do_reset(1'b1);
        bus(1, OSC_CTRL_ADDR, 0, 4'hF);
        check("lock after reset", rv[LOCK_BIT], 0);
        for (int k = 0; k < NUM_OUT_REGS; k++) begin
            bus(1, OUT_BASE_ADDR + 8'(4 * k), 0, 4'hF);
            check("output route reset", rv, 0);
        end
        for (int k = 0; k < NUM_IN_REGS; k++) begin
            bus(1, IN_BASE_ADDR + 8'(4 * k), 0, 4'hF);
            check("input route reset", rv, 32'h00003F3F);
        end
        bus(1, 8'h3C, 0, 4'hF);
        $display("test reset values done");
        // Every code, plus one beyond the table, on two pins at once.
        for (int f = 0; f < 29; f++) begin
            c = (f == 28) ? 6'h3F : 6'(f);
            bus(0, OUT_BASE_ADDR, {18'h0, c, 2'b00, c}, 4'hF);
            for (int b = 0; b < 2; b++) begin
                fv = NUM_FUNCS'($urandom);
                if (f >= 1 && f <= 27) fv[f] = b[0];
                funcs <= fv;
                repeat (3) @(posedge clk_in);
                check("pin enable", poe[1:0], {2{f >= 1 && f <= 27}});
                if (f >= 1 && f <= 27) check("pin data", pdata[1:0], {2{b[0]}});
            end
        end
        $display("test output decode done");
        foreach (ks[i]) begin
            d = $urandom;
            bus(0, OUT_BASE_ADDR + 8'(4 * ks[i]), d, 4'hF);
            bus(1, OUT_BASE_ADDR + 8'(4 * ks[i]), 0, 4'hF);
            check("absent field", rv, out_exp(ks[i], d));
        end
        $display("test absent pins done");
        p = 14 + $urandom % 10;
        e = NUM_PINS'($urandom);
        e[4] = 1'b1;
        ext <= e;
        bus(0, IN_BASE_ADDR, {18'h0, MISSING_PIN_A, 2'b00, 6'(p)}, 4'hF);
        bus(0, IN_BASE_ADDR + 8'h04, {18'h0, 6'(p), 2'b00, INPUT_ONLY_PIN}, 4'hF);
        repeat (3) @(posedge clk_in);
        check("input map", pmap[31:0], {28'h0, e[p], e[25], 1'b0, e[p]});
        $display("test input map done");
        for (int cw = 1; cw >= 0; cw--) begin
            do_reset(cw[0]);
            bus(1, STATUS_ADDR, 0, 4'hF);
            check("one way option", rv[ST_ONE_WAY], cw[0]);
            key(1'b1);
            bus(1, OSC_CTRL_ADDR, 0, 4'hF);
            check("lock set", rv[LOCK_BIT], 1);
            d = $urandom;
            bus(0, OUT_BASE_ADDR + 8'h1C, d, 4'hF);
            bus(1, OUT_BASE_ADDR + 8'h1C, 0, 4'hF);
            check("locked write", rv, 0);
            bus(0, OSC_CTRL_ADDR, {24'h0, KEY_FIRST}, 4'h1);
            bus(0, OUT_BASE_ADDR + 8'h1C, d, 4'hF);
            bus(0, OSC_CTRL_ADDR, {24'h0, KEY_SECOND}, 4'h1);
            bus(0, OSC_CTRL_ADDR, 0, 4'h1);
            bus(1, OSC_CTRL_ADDR, 0, 4'hF);
            check("aborted key", rv[LOCK_BIT], 1);
            key(1'b0);
            bus(1, OSC_CTRL_ADDR, 0, 4'hF);
            check("unlock", rv[LOCK_BIT], cw[0]);
            for (int k = 7; k < 9; k++) begin
                bus(0, OUT_BASE_ADDR + 8'(4 * k), d, 4'hF);
                bus(1, OUT_BASE_ADDR + 8'(4 * k), 0, 4'hF);
                check("session write", rv, cw[0] ? 32'h0 : out_exp(k, d));
            end
            // A write on the high lane alone must leave the low selector as it was.
            bus(0, OUT_BASE_ADDR + 8'h1C, ~d, 4'h2);
            bus(1, OUT_BASE_ADDR + 8'h1C, 0, 4'hF);
            check("byte lane", rv, cw[0] ? 32'h0 : {18'h0, ~d[13:8], 2'b00, d[5:0]});
            $display("test lock done");
        end
        check("mismatch reset", mism, 0);
        stop_test();
    end
endmodule
bind ros_pin_route ros_pin_route_sva SVA (.clk_in(clk_in), .rstn_in(rstn_in),
    .av_req_in(av_req_in), .av_readdata_out(av_readdata_out),
    .av_waitrequest_out(av_waitrequest_out), .pin_oe_out(pin_oe_out),
    .periph_in_out(periph_in_out), .mismatch_reset_out(mismatch_reset_out));
